// *** shared/pco_pkg.sv ***
package pco_pkg;
    localparam int PCO_CNT_W = 32;
    localparam int PCO_PW_W = 16;
    localparam logic [PCO_CNT_W-1:0] PCO_CNT_ZERO = 32'h0000_0000;
    localparam logic [PCO_CNT_W-1:0] PCO_CNT_ONE = 32'h0000_0001;
    localparam logic [PCO_PW_W-1:0] PCO_PW_ZERO = 16'h0000;
    localparam logic [PCO_PW_W-1:0] PCO_PW_ONE = 16'h0001;

    typedef enum logic [1:0] {
        PCO_IDLE = 2'b00,
        PCO_RUN = 2'b01,
        PCO_HIT = 2'b11
    } pco_state_t;

    typedef struct packed {
        logic one_shot;
        logic level_high;
        logic [PCO_CNT_W-1:0] preset_count;
        logic [PCO_PW_W-1:0] pulse_ticks;
    } pco_cfg_t;
endpackage

// *** hdl/pco_preset_count_output.sv ***
`timescale 1ns/10ps
module pco_preset_count_output (
    input wire logic mclk,
    input wire logic rst_b,
    input pco_pkg::pco_cfg_t cfg,
    input wire logic external_control_input,
    input wire logic local_clear,
    input wire logic count_fwd,
    input wire logic count_rev,
    output logic contact_output_one,
    output logic [pco_pkg::PCO_CNT_W-1:0] fwd_total_q,
    output logic [pco_pkg::PCO_CNT_W-1:0] rev_total_q,
    output logic [pco_pkg::PCO_CNT_W-1:0] preset_point_q,
    output logic counting
);
    import pco_pkg::*;

    logic hold;
    logic clear;
    logic reached;
    logic [PCO_CNT_W-1:0] running;
    logic [PCO_PW_W-1:0] width_q;
    pco_state_t state_q;

    assign hold = cfg.level_high ? external_control_input : !external_control_input;
    assign clear = hold || local_clear;
    assign counting = !hold;
    // The running count wraps at the counter width, like each total does.
    assign running = PCO_CNT_W'(fwd_total_q + rev_total_q);
    assign reached = running >= preset_point_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fwd_total_q <= PCO_CNT_ZERO;
            rev_total_q <= PCO_CNT_ZERO;
        end else if (clear) begin
            fwd_total_q <= PCO_CNT_ZERO;
            rev_total_q <= PCO_CNT_ZERO;
        end else begin
            if (count_fwd) begin
                fwd_total_q <= fwd_total_q + PCO_CNT_ONE;
            end
            if (count_rev) begin
                rev_total_q <= rev_total_q + PCO_CNT_ONE;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            preset_point_q <= PCO_CNT_ZERO;
        end else if (clear) begin
            preset_point_q <= cfg.preset_count;
        end else if (cfg.one_shot && reached) begin
            preset_point_q <= PCO_CNT_W'(preset_point_q + cfg.preset_count);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= PCO_IDLE;
            width_q <= PCO_PW_ZERO;
        end else if (clear) begin
            state_q <= PCO_IDLE;
            width_q <= PCO_PW_ZERO;
        end else if (reached) begin
            state_q <= PCO_HIT;
            width_q <= cfg.pulse_ticks;
        end else if (state_q == PCO_HIT && cfg.one_shot) begin
            if (width_q <= PCO_PW_ONE) begin
                state_q <= PCO_RUN;
                width_q <= PCO_PW_ZERO;
            end else begin
                width_q <= width_q - PCO_PW_ONE;
            end
        end else if (state_q == PCO_IDLE) begin
            state_q <= PCO_RUN;
        end
    end

    assign contact_output_one = (state_q == PCO_HIT);

    a_hold_stays_on: assert property (@(posedge mclk) disable iff (!rst_b)
        contact_output_one && !cfg.one_shot && !clear |=> contact_output_one)
        else $error("Level-hold output dropped without clear.");

    a_clear_zeroes: assert property (@(posedge mclk) disable iff (!rst_b)
        clear |=> fwd_total_q == PCO_CNT_ZERO && rev_total_q == PCO_CNT_ZERO)
        else $error("Clear did not zero both totals.");

    a_clear_drops: assert property (@(posedge mclk) disable iff (!rst_b)
        clear |=> !contact_output_one)
        else $error("Output stayed on through clear.");

    a_hit_asserts: assert property (@(posedge mclk) disable iff (!rst_b)
        reached && !clear |=> contact_output_one)
        else $error("Hit did not assert output.");

    a_rearm_adds: assert property (@(posedge mclk) disable iff (!rst_b)
        cfg.one_shot && reached && !clear |=>
        preset_point_q == $past(preset_point_q) + $past(cfg.preset_count))
        else $error("Preset point not advanced by preset count.");

    // A hit that the clear does not override.
    sequence s_hit_taken;
        reached && !clear;
    endsequence

    // A hit taken while the one-shot mode is selected.
    sequence s_one_shot_hit;
        cfg.one_shot && reached && !clear;
    endsequence

    // A one-shot pulse that is running with no new hit and no clear.
    sequence s_pulse_running;
        cfg.one_shot && state_q == PCO_HIT && !reached && !clear;
    endsequence

    a_width_ends: assert property (@(posedge mclk) disable iff (!rst_b)
        s_pulse_running ##0 (width_q <= PCO_PW_ONE) |=> !contact_output_one)
        else $error("One-shot output outlived its width.");

    a_width_counts: assert property (@(posedge mclk) disable iff (!rst_b)
        s_pulse_running ##0 (width_q > PCO_PW_ONE) |=>
        contact_output_one && width_q == $past(width_q) - PCO_PW_ONE)
        else $error("One-shot width not counted down.");

    a_retrigger_holds: assert property (@(posedge mclk) disable iff (!rst_b)
        s_one_shot_hit |=> contact_output_one && width_q == $past(cfg.pulse_ticks))
        else $error("Retrigger did not reload the pulse width.");

    a_hit_state: assert property (@(posedge mclk) disable iff (!rst_b)
        s_hit_taken |=> state_q == PCO_HIT)
        else $error("Hit did not enter the hit state.");

    a_clear_reloads: assert property (@(posedge mclk) disable iff (!rst_b)
        clear |=> preset_point_q == $past(cfg.preset_count))
        else $error("Clear did not reload the preset point.");

    a_fwd_counts: assert property (@(posedge mclk) disable iff (!rst_b)
        !clear && count_fwd |=> fwd_total_q == $past(fwd_total_q) + PCO_CNT_ONE)
        else $error("Forward count pulse not totalized.");

    a_rev_counts: assert property (@(posedge mclk) disable iff (!rst_b)
        !clear && count_rev |=> rev_total_q == $past(rev_total_q) + PCO_CNT_ONE)
        else $error("Reverse count pulse not totalized.");

    a_totals_still: assert property (@(posedge mclk) disable iff (!rst_b)
        !clear && !count_fwd && !count_rev |=>
        fwd_total_q == $past(fwd_total_q) && rev_total_q == $past(rev_total_q))
        else $error("Totals changed with no count pulse.");

    a_level_no_rearm: assert property (@(posedge mclk) disable iff (!rst_b)
        !cfg.one_shot && !clear |=> preset_point_q == $past(preset_point_q))
        else $error("Preset point moved in level-hold mode.");

    a_level_stays_off: assert property (@(posedge mclk) disable iff (!rst_b)
        !cfg.one_shot && !contact_output_one && !reached |=> !contact_output_one)
        else $error("Level-hold output rose without a hit.");

    a_hold_not_counting: assert property (@(posedge mclk) disable iff (!rst_b)
        !counting |=> fwd_total_q == PCO_CNT_ZERO && rev_total_q == PCO_CNT_ZERO)
        else $error("Totals moved while held by the control input.");

    a_idle_leaves: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == PCO_IDLE && !clear && !reached |=> state_q == PCO_RUN)
        else $error("Idle state not left after release.");
endmodule

// *** tb/pco_plant.sv ***
`timescale 1ns/10ps
module pco_plant (
    input wire logic mclk,
    input wire logic en,
    output logic pulse
);
    logic [3:0] n_q;
    always_ff @(posedge mclk) begin
        n_q <= en ? n_q + 4'h1 : 4'h0;
        pulse <= en && n_q == 4'h7;
    end
endmodule

// *** tb/preset_count_output_test.sv ***
`timescale 1ns/10ps
module preset_count_output_test;
    import pco_pkg::*;
    logic mclk = 0, rst_b = 0, ctl = 1, clr = 0, en = 0, rev = 0, fwd, out, cnt;
    pco_cfg_t cfg = '{1'b0, 1'b1, 32'h3, 16'h4};
    logic [PCO_CNT_W-1:0] ft, rt, pp;
    int miscompares = 0, comparisons = 0;
    pco_preset_count_output dut_u (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
        .external_control_input(ctl), .local_clear(clr), .count_fwd(fwd),
        .count_rev(rev), .contact_output_one(out), .fwd_total_q(ft),
        .rev_total_q(rt), .preset_point_q(pp), .counting(cnt));
    pco_plant plant_u (.mclk(mclk), .en(en), .pulse(fwd));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        #1 comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_out;
        for (int i = 0; i < 200 && out !== 1'b1; i++) begin
            tick(1);
            #1;
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000 miscompares++;
        report_and_stop();
    end
    initial begin
        tick(6);
        rst_b <= 1;
        en <= 1;
        tick(12);
        chk(ft, 0);
        chk(pp, 3);
        chk(cnt, 0);
        tick(1);
        ctl <= 0;
        rev <= 1;
        tick(1);
        rev <= 0;
        chk(cnt, 1);
        wait_out();
        chk(out, 1);
        chk(ft + rt >= 3, 1);
        tick(40);
        chk(out, 1);
        ctl <= 1;
        tick(2);
        chk(ft | rt, 0);
        chk(out, 0);
        cfg <= '{1'b1, 1'b0, 32'h3, 16'h4};
        ctl <= 0;
        tick(2);
        chk(ft, 0);
        ctl <= 1;
        wait_out();
        chk(out, 1);
        chk(pp, 6);
        tick(6);
        chk(out, 0);
        wait_out();
        chk(out, 1);
        chk(pp, 9);
        tick(1);
        clr <= 1;
        tick(2);
        chk(ft | out, 0);
        report_and_stop();
    end
endmodule
